// File: design/interrupt_vector_priority.v
// Vector and priority resolution for the DSP core, with AXI4-Lite register access
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`include "ivp_map.vh"

module interrupt_vector_priority (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [4:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [4:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   input  wire [31:0] src_req,
   input  wire        nmi_req,
   output reg         irq_out,
   output reg  [4:0]  irq_slot,
   output reg  [31:0] irq_vector
);

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------
   function [4:0] prio_of;
      input [4:0] slot;
      reg [159:0] tab;
      begin
         tab = `PRIO_TABLE;
         prio_of = tab[slot*5 +: 5];
      end
   endfunction

   function high_range;
      input [4:0] slot;
      begin
         high_range = (slot >= `HIGH_FIRST) && (slot <= `HIGH_LAST);
      end
   endfunction

   function [31:0] strobe;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer i;
      begin
         strobe = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               strobe[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   reg  [31:0] flag_q;
   reg  [31:0] enable_q;
   reg  [31:0] ptr_low_q;
   reg  [31:0] ptr_high_q;
   reg  [31:0] trap_q;
   reg         aw_full_q;
   reg         w_full_q;
   reg  [4:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   wire [31:0] req_raw;
   wire [31:0] pending;
   reg  [4:0]  best_slot;
   reg  [4:0]  best_prio;
   reg         best_any;
   integer     k;

   // Non-maskable line is ignored: this device never asserts it
   assign req_raw = {src_req[31:`SLOT_NMI+1], 1'b0, src_req[0]};
   // Software traps share the hardware slot and vector path
   assign pending = (flag_q & enable_q) | trap_q;

   // ----------------------------------------------------------------------------
   // Priority resolution
   // ----------------------------------------------------------------------------
   // Linear scan; ties are impossible except the reused 14/15/16/17/18 values, where
   // the lower slot wins as it is seen first.
   always @* begin
      best_any  = 1'b0;
      best_slot = 5'h00;
      best_prio = `PRIO_IDLE;
      for (k = 0; k < `NUM_SLOTS; k = k + 1) begin
         if (pending[k] && (!best_any || prio_of(k[4:0]) < best_prio)) begin
            best_any  = 1'b1;
            best_slot = k[4:0];
            best_prio = prio_of(k[4:0]);
         end
      end
   end
   // Slot map: 2/3 external, 5/7/9/11 shared ports, 13 converter, 18 wake, 26 kernel

   // ----------------------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------------------
   assign awready = !aw_full_q && !bvalid;
   assign wready  = !w_full_q && !bvalid;
   assign arready = !rvalid;

   wire        wr_go = aw_full_q && w_full_q && !bvalid;
   wire        ack_wr = wr_go && (aw_addr_q == `OFS_ACK);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q  <= 1'b0;
         w_full_q   <= 1'b0;
         aw_addr_q  <= 5'h00;
         w_data_q   <= 32'h0000_0000;
         w_strb_q   <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= `RESP_OKAY;
         flag_q     <= 32'h0000_0000;
         enable_q   <= 32'h0000_0000;
         ptr_low_q  <= `PTR_RST;
         ptr_high_q <= `PTR_RST;
         trap_q     <= 32'h0000_0000;
      end else begin
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= `RESP_OKAY;
            case (aw_addr_q)
               `OFS_FLAG, `OFS_TRAP, `OFS_ACK, `OFS_VECTOR: ;
               `OFS_ENABLE:   enable_q   <= strobe(enable_q, w_data_q, w_strb_q);
               `OFS_PTR_LOW:  ptr_low_q  <= strobe(ptr_low_q, w_data_q, w_strb_q);
               `OFS_PTR_HIGH: ptr_high_q <= strobe(ptr_high_q, w_data_q, w_strb_q);
               default:       bresp      <= `RESP_SLVERR;
            endcase
         end
         // Flags: write-one-to-clear, a new request in the same cycle wins
         flag_q <= ((wr_go && aw_addr_q == `OFS_FLAG) ?
                    (flag_q & ~strobe(32'h0000_0000, w_data_q, w_strb_q)) : flag_q)
                   | req_raw;
         // Traps: software sets, acknowledge of the served slot clears
         trap_q <= ((wr_go && aw_addr_q == `OFS_TRAP) ?
                    (trap_q | strobe(32'h0000_0000, w_data_q, w_strb_q)) : trap_q)
                   & ~((ack_wr && best_any) ? (32'h0000_0001 << best_slot) : 32'h0000_0000);
         if (ack_wr && best_any && flag_q[best_slot] && !req_raw[best_slot]) begin
            flag_q[best_slot] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Vector output and read path
   // ----------------------------------------------------------------------------
   wire [31:0] vec_base = high_range(best_slot) ? ptr_high_q : ptr_low_q;
   wire [31:0] vec_addr = vec_base + ({27'h0000000, best_slot} << `VEC_SHIFT);

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_out    <= 1'b0;
         irq_slot   <= 5'h00;
         irq_vector <= 32'h0000_0000;
         rvalid     <= 1'b0;
         rdata      <= 32'h0000_0000;
         rresp      <= `RESP_OKAY;
      end else begin
         irq_out    <= best_any;
         irq_slot   <= best_slot;
         irq_vector <= vec_addr;
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= `RESP_OKAY;
            case (araddr)
               `OFS_FLAG:     rdata <= flag_q;
               `OFS_ENABLE:   rdata <= enable_q;
               `OFS_PTR_LOW:  rdata <= ptr_low_q;
               `OFS_PTR_HIGH: rdata <= ptr_high_q;
               `OFS_TRAP:     rdata <= trap_q;
               `OFS_VECTOR:   rdata <= vec_addr;
               `OFS_ACK:      rdata <= {26'h0000000, best_any, best_slot};
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end

endmodule // interrupt_vector_priority

// File: inc/ivp_map.vh
// Register offsets, field positions, priorities and reset values of the vector/priority block
// ----------------------------------------------------------------------------
// Overview of operation
// - Slot n, and software trap n, sit at relative byte offset eight times n.
// - Slot 0 is reset, offset zero, priority zero, the highest of all.
// - Non-maskable request is held deasserted; slot 1 stays usable by trap one.
// - Slots 0-15 and 24-31 use the low-range pointer plus relative offset.
// - Slots 16-23 use the high-range pointer plus relative offset.
// - First external user request is slot 2, offset 0x10, priority 3.
// - Second external user request is slot 3, offset 0x18, priority 5.
// - Slot 5, priority 7, carries port 0 transmit or card 0 request.
// - Slot 7, priority 10, carries port 0 receive or card 0 SDIO request.
// - Slot 9, priority 13, carries port 1 transmit or card 1 request.
// - Slot 11, priority 15, carries port 1 receive or card 1 SDIO request.
// - Slot 13, priority 18, carries converter done or pin request.
// - Slot 18, priority 12, carries wake-up pin or real-time clock request.
// - Slot 26, priority 26, carries the operating system kernel request.
// - Each maskable source has flag and enable bits at one position, reset zero.
// - In the first pair, serial port 2 receive is bit 15, DMA bit 8.
// ----------------------------------------------------------------------------
`ifndef IVP_MAP_VH
`define IVP_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_FLAG       5'h00
`define OFS_ENABLE     5'h04
`define OFS_PTR_LOW    5'h08
`define OFS_PTR_HIGH   5'h0C
`define OFS_TRAP       5'h10
`define OFS_VECTOR     5'h14
`define OFS_ACK        5'h18

// ----------------------------------------------------------------------------
// Geometry and reset values
// ----------------------------------------------------------------------------
`define NUM_SLOTS      32
`define VEC_SHIFT      3
`define HIGH_FIRST     5'h10
`define HIGH_LAST      5'h17
`define PRIO_IDLE      5'h1F
`define PTR_RST        32'h0000_0000
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define SLOT_NMI       1
`define SLOT_SER2_RX   15
`define SLOT_DMA       8

// Fixed priority per slot, slot 0 in the low five bits
`define PRIO_TABLE {5'h12,5'h11,5'h10,5'h0F,5'h0E,5'h1A,5'h19,5'h02, \
                    5'h18,5'h17,5'h14,5'h13,5'h10,5'h0C,5'h08,5'h04, \
                    5'h16,5'h15,5'h12,5'h11,5'h0F,5'h0E,5'h0D,5'h0B, \
                    5'h0A,5'h09,5'h07,5'h06,5'h05,5'h03,5'h01,5'h00}

`endif

// File: sim/source_model.sv
// Peripheral request source model
module source_model (
   input  wire        aclk,
   input  wire [31:0] fire,
   output reg  [31:0] src_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // One-cycle pulses, so an acknowledged flag is not set again by a held level
   always @(posedge aclk)
      src_req <= fire;
endmodule // source_model

// File: sim/ivp_properties.sv
// Bus and interrupt assertions for the vector/priority block
module ivp_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire [4:0]  awaddr,
   input wire        awvalid,
   input wire        awready,
   input wire        wvalid,
   input wire        wready,
   input wire [1:0]  bresp,
   input wire        bvalid,
   input wire [4:0]  araddr,
   input wire        arvalid,
   input wire        arready,
   input wire [31:0] rdata,
   input wire [1:0]  rresp,
   input wire        rvalid,
   input wire        rready,
   input wire        irq_out,
   input wire [4:0]  irq_slot
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rst; $rose(aresetn) |-> !irq_out && !bvalid && !rvalid; endproperty
   a_rst: assert property (p_rst) else $error("outputs set after reset");
   // Response register loads one edge after both holders fill, so it shows two edges on
   property p_wr; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_wr: assert property (p_wr) else $error("no write response");
   property p_bref; bvalid |-> !awready && !wready; endproperty
   a_bref: assert property (p_bref) else $error("write taken during response");
   property p_rd; arvalid && arready |=> rvalid; endproperty
   a_rd: assert property (p_rd) else $error("no read data");
   property p_rref; rvalid |-> !arready; endproperty
   a_rref: assert property (p_rref) else $error("read taken during data");
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_badr; arvalid && arready && araddr > 5'h18 |=> rresp == 2'h2 && rdata == 0;
   endproperty
   a_badr: assert property (p_badr) else $error("unmapped read accepted");
   property p_badw; awvalid && awready && wvalid && wready && awaddr > 5'h18
      |-> ##2 bresp == 2'h2; endproperty
   a_badw: assert property (p_badw) else $error("unmapped write accepted");
   c_top: cover property (irq_out && irq_slot == 5'h00);
   c_high: cover property (irq_out && irq_slot == 5'h12);
   c_err: cover property (bvalid && bresp == 2'h2);
endmodule // ivp_checker

bind interrupt_vector_priority ivp_checker ivp_checker_i (.aclk, .aresetn, .awaddr, .awvalid,
   .awready, .wvalid, .wready, .bresp, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp,
   .rvalid, .rready, .irq_out, .irq_slot);

// File: sim/interrupt_vector_priority_tb.sv
// Self-checking bench for the vector/priority block
`include "ivp_map.vh"
module interrupt_vector_priority_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0;
   logic [4:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, fire = 0, m = 0;
   wire         awready, wready, bvalid, arready, rvalid, irq_out;
   wire  [1:0]  bresp, rresp;
   wire  [4:0]  irq_slot;
   wire  [31:0] src_req, rdata, irq_vector;
   int          n_mismatch = 0, tests_run = 0, cyc = 0;
   int          ord[12] = '{0, 2, 3, 5, 7, 8, 18, 9, 11, 13, 15, 26};
   always #12.5 aclk = ~aclk;
   interrupt_vector_priority interrupt_vector_priority_i (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .src_req, .nmi_req(1'b1),
      .irq_out, .irq_slot, .irq_vector);
   source_model source_model_i (.aclk, .fire, .src_req);
   function automatic logic [31:0] ev(int n);
      return (n > 15 && n < 24 ? 32'h0000_8000 : 32'h0000_1000) + 32'(8 * n);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      bit ta = 0, tw = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (!ta && awready) begin
            ta = 1;
            awvalid <= 0;
         end
         if (!tw && wready) begin
            tw = 1;
            wvalid <= 0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      chk(bresp, er);
      bready <= 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      chk(rdata, e);
      chk(rresp, er);
      rready <= 0;
   endtask
   task automatic pulse(input logic [31:0] p);
      @(posedge aclk);
      fire <= p;
      @(posedge aclk);
      fire <= 0;
      repeat (4) @(posedge aclk);
   endtask
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude;
      end
   end
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      rd(`OFS_ENABLE, 0);
      rd(`OFS_FLAG, 0);
      wr(5'h1C, 1, `RESP_SLVERR);
      rd(5'h1C, 0, `RESP_SLVERR);
      wr(`OFS_PTR_LOW, 32'h0000_1000);
      wr(`OFS_PTR_HIGH, 32'h0000_8000);
      rd(`OFS_PTR_HIGH, 32'h0000_8000);
      pulse(32'h0000_0004);
      chk(irq_out, 0);
      rd(`OFS_FLAG, 32'h0000_0004);
      wr(`OFS_ENABLE, 32'hFFFF_FFFF);
      repeat (2) @(posedge aclk);
      chk(irq_slot, 2);
      chk(irq_vector, 32'h0000_1010);
      wr(`OFS_FLAG, 32'h0000_0004);
      repeat (2) @(posedge aclk);
      chk(irq_out, 0);
      for (int n = 0; n < 32; n++) begin
         wr(`OFS_TRAP, 32'h0000_0001 << n);
         repeat (2) @(posedge aclk);
         chk(irq_slot, n);
         chk(irq_vector, ev(n));
         wr(`OFS_ACK, 0);
      end
      foreach (ord[i]) m |= 32'h0000_0001 << ord[i];
      // Request on slot 1 as well: the flag must still ignore it
      pulse(m | 32'h0000_0002);
      // Bit 1 stays clear although the non-maskable input is high
      rd(`OFS_FLAG, m);
      foreach (ord[i]) begin
         chk(irq_slot, ord[i]);
         chk(irq_vector, ev(ord[i]));
         wr(`OFS_ACK, 0);
         repeat (2) @(posedge aclk);
      end
      chk(irq_out, 0);
      conclude;
   end
endmodule // interrupt_vector_priority_tb
